// ### design/stc_pkg.sv
// Constants, state types and field codes for the split timer with PWM and clock output
// Summary of operation
// - Split capture-auto-zero mode: two 8-bit counters, upper byte captured and zeroed.
// - Split PWM: upper count and upper reload form an 8-bit auto-reload period counter.
// - Split PWM: lower count is the compare value, lower reload buffers new duty.
// - Split PWM: each upper overflow sets upper flag and copies lower reload.
// - PWM appears on the clock-out pin only while clock-out enable is set.
// - Split duty capture: two 8-bit counters, duty capture done on the upper byte.
// - Capture/reload select 0 with clock-out enable 1 gives 50% duty clock, except in split PWM.
// - Unsplit clock-out counts 16 bits from any of the eight upper clock sources.
// - Unsplit clock-out: each overflow loads the 16-bit reload pair and counting continues.
// - Output toggles once per overflow, so frequency is clock over twice the period.
// - Unsplit clock-out still sets upper flag; overflow-ignore masks its interrupt.
// - Split clock-out toggles on lower overflows; lower reload reloads lower count.
// - Lower counter in split mode has four clock sources from a two-bit select.
// - Lower rollovers used for split clock-out do not raise the lower overflow flag.
// - Lower counter serves as baud generator and clock generator at the same rate.
// - Lower overflow sets lower flag; it requests interrupt only when enabled.
// - In split mode the lower overflow is the overflow event offered outside.
// - External, upper and lower flags stay set until software clears them.
// - Split mode: upper counter gated by upper run, lower counter by lower run.
// - Mode bits high, capture/reload, low equal to 1 0 0 decode split PWM.
package stc_pkg;

	// ******************************************************************
	// Mode codes {high, capture_reload, low}
	// ******************************************************************
	localparam logic [2:0] MODE_AR_EXT  = 3'h0;
	localparam logic [2:0] MODE_AR_TRIG = 3'h1;
	localparam logic [2:0] MODE_CAPT    = 3'h2;
	localparam logic [2:0] MODE_CAPT_AZ = 3'h3;
	localparam logic [2:0] MODE_PWM     = 3'h4;
	localparam logic [2:0] MODE_DUTY    = 3'h6;

	// ******************************************************************
	// Clock sources and timing
	// ******************************************************************
	localparam logic [2:0] USRC_DIV12   = 3'h0;
	localparam logic [2:0] USRC_PIN     = 3'h1;
	localparam logic [2:0] USRC_SYSCLK  = 3'h2;
	localparam logic [2:0] USRC_CHAIN   = 3'h3;
	localparam logic [2:0] USRC_S1TOF   = 3'h4;
	localparam logic [2:0] USRC_T0OF    = 3'h5;
	localparam logic [2:0] USRC_AC1ES   = 3'h6;
	localparam logic [2:0] USRC_T1OF    = 3'h7;
	localparam logic [1:0] LSRC_DIV12   = 2'h0;
	localparam logic [1:0] LSRC_SYSCLK  = 2'h1;
	localparam logic [1:0] LSRC_S1TOF   = 2'h2;
	localparam logic [1:0] LSRC_INT1ET  = 2'h3;
	localparam logic [3:0] PRESC_LAST   = 4'hb;
	localparam logic [7:0] BYTE_MAX     = 8'hff;

	typedef enum logic [1:0] {
		DUTY_WAIT   = 2'b00,
		DUTY_FIRST  = 2'b01,
		DUTY_SECOND = 2'b10,
		DUTY_DONE   = 2'b11
	} stc_duty_t;

	typedef struct packed {
		logic [3:0] presc;
		logic [1:0] pin_sync;
		logic       pin_prev;
		logic [1:0] cap_sync;
		logic       cap_prev;
		logic [7:0] upper;
		logic [7:0] lower;
		logic [7:0] upper_rl;
		logic [7:0] lower_rl;
		logic       upper_flag;
		logic       lower_flag;
		logic       ext_flag;
		logic       clk_tog;
		logic       pwm_lvl;
		logic       pin_out;
		logic       duty_stop;
		stc_duty_t  duty;
		logic       tmr_ovf_ev;
		logic       low_ovf_ev;
	} stc_state_t;

	localparam stc_state_t STATE_RESET = '{
		presc: 4'h0, pin_sync: 2'h0, pin_prev: 1'b0, cap_sync: 2'h0, cap_prev: 1'b0,
		upper: 8'h00, lower: 8'h00, upper_rl: 8'h00, lower_rl: 8'h00,
		upper_flag: 1'b0, lower_flag: 1'b0, ext_flag: 1'b0, clk_tog: 1'b0,
		pwm_lvl: 1'b0, pin_out: 1'b0, duty_stop: 1'b0, duty: DUTY_WAIT,
		tmr_ovf_ev: 1'b0, low_ovf_ev: 1'b0};

endpackage

// ### design/stc_split_timer.sv
// Split 16-bit timer with 8-bit PWM, duty capture and 50% clock output
`timescale 1ns/1ps
module stc_split_timer (
	// Clock and reset
	input  wire logic       CORE_CLK,
	input  wire logic       RESET,
	// Mode and run control
	input  wire logic       SPLIT_ENABLE,
	input  wire logic       MODE_SELECT_HIGH,
	input  wire logic       CAPTURE_RELOAD_SELECT,
	input  wire logic       MODE_SELECT_LOW,
	input  wire logic       CLOCK_OUT_ENABLE,
	input  wire logic       UPPER_RUN,
	input  wire logic       LOWER_RUN,
	input  wire logic       OVERFLOW_IGNORE,
	input  wire logic       LOWER_OVERFLOW_IRQ_ENABLE,
	input  wire logic       EXT_FALL_ENABLE,
	input  wire logic       EXT_RISE_ENABLE,
	// Clock source selects
	input  wire logic [2:0] UPPER_CLOCK_SELECT,
	input  wire logic       LOWER_CLOCK_SELECT_HIGH,
	input  wire logic       LOWER_CLOCK_SELECT_LOW,
	// Count sources, same-clock pulses
	input  wire logic       S1_OVERFLOW_EVENT,
	input  wire logic       T0_OVERFLOW_EVENT,
	input  wire logic       T1_OVERFLOW_EVENT,
	input  wire logic       AC1_EVENT,
	input  wire logic       INT1_EVENT,
	// Asynchronous pins
	input  wire logic       COUNT_PIN,
	input  wire logic       CAPTURE_PIN,
	// Software writes and flag clears
	input  wire logic [7:0] WR_DATA,
	input  wire logic       WR_UPPER_COUNT,
	input  wire logic       WR_LOWER_COUNT,
	input  wire logic       WR_UPPER_RELOAD,
	input  wire logic       WR_LOWER_RELOAD,
	input  wire logic       CLR_UPPER_OVF,
	input  wire logic       CLR_LOWER_OVF,
	input  wire logic       CLR_EXT_EVENT,
	// Counter and reload contents
	output logic      [7:0] UPPER_COUNT_BYTE,
	output logic      [7:0] LOWER_COUNT_BYTE,
	output logic      [7:0] UPPER_RELOAD_BYTE,
	output logic      [7:0] LOWER_RELOAD_BYTE,
	// Status and events
	output logic            UPPER_OVERFLOW_FLAG,
	output logic            LOWER_OVERFLOW_FLAG,
	output logic            EXTERNAL_EVENT_FLAG,
	output logic            IRQ,
	output logic            TIMER_OVERFLOW_EVENT,
	output logic            LOWER_OVERFLOW_EVENT,
	output logic            CLOCK_OUT_PIN
);

	// ******************************************************************
	// State and decode
	// ******************************************************************
	stc_pkg::stc_state_t state_reg;
	stc_pkg::stc_state_t state_next;

	logic [2:0]  mode;
	logic        pwm_mode;
	logic        duty_mode;
	logic        clkout_mode;
	logic        tick12;
	logic        lower_tick;
	logic        upper_tick;
	logic        lower_go;
	logic        upper_go;
	logic        low_ovf;
	logic        ovf_u;
	logic        ovf16;
	logic        timer_ovf;
	logic        cap_rise;
	logic        cap_fall;
	logic        ext_edge;
	logic        capture;
	logic        duty_hold;
	logic [15:0] cnt16;

	assign mode        = {MODE_SELECT_HIGH, CAPTURE_RELOAD_SELECT, MODE_SELECT_LOW};
	assign pwm_mode    = SPLIT_ENABLE && (mode == stc_pkg::MODE_PWM);
	assign duty_mode   = (mode == stc_pkg::MODE_DUTY);
	assign clkout_mode = !CAPTURE_RELOAD_SELECT && CLOCK_OUT_ENABLE && !pwm_mode;
	assign cnt16       = {state_reg.upper, state_reg.lower};

	function automatic logic [7:0] inc8(input logic [7:0] v);
		inc8 = v + 8'h01;
	endfunction

	// ******************************************************************
	// Next-state logic
	// ******************************************************************
	always_comb begin
		state_next = state_reg;

		// Prescaler for the divided-by-twelve source
		tick12 = (state_reg.presc == stc_pkg::PRESC_LAST);
		state_next.presc = tick12 ? 4'h0 : state_reg.presc + 4'h1;

		// Pins pass two flops before the edge detectors look at them
		state_next.pin_sync = {state_reg.pin_sync[0], COUNT_PIN};
		state_next.pin_prev = state_reg.pin_sync[1];
		state_next.cap_sync = {state_reg.cap_sync[0], CAPTURE_PIN};
		state_next.cap_prev = state_reg.cap_sync[1];
		cap_rise = state_reg.cap_sync[1] && !state_reg.cap_prev;
		cap_fall = !state_reg.cap_sync[1] && state_reg.cap_prev;
		ext_edge = (cap_fall && EXT_FALL_ENABLE) || (cap_rise && EXT_RISE_ENABLE);

		unique case ({LOWER_CLOCK_SELECT_HIGH, LOWER_CLOCK_SELECT_LOW})
			stc_pkg::LSRC_DIV12:  lower_tick = tick12;
			stc_pkg::LSRC_SYSCLK: lower_tick = 1'b1;
			stc_pkg::LSRC_S1TOF:  lower_tick = S1_OVERFLOW_EVENT;
			stc_pkg::LSRC_INT1ET: lower_tick = INT1_EVENT;
		endcase

		// The compare byte must hold still while PWM runs
		lower_go = SPLIT_ENABLE && LOWER_RUN && lower_tick && !pwm_mode;
		low_ovf  = lower_go && (state_reg.lower == stc_pkg::BYTE_MAX);

		unique case (UPPER_CLOCK_SELECT)
			stc_pkg::USRC_DIV12:  upper_tick = tick12;
			stc_pkg::USRC_PIN:    upper_tick = state_reg.pin_prev && !state_reg.pin_sync[1];
			stc_pkg::USRC_SYSCLK: upper_tick = 1'b1;
			stc_pkg::USRC_CHAIN:  upper_tick = SPLIT_ENABLE ? low_ovf : INT1_EVENT;
			stc_pkg::USRC_S1TOF:  upper_tick = S1_OVERFLOW_EVENT;
			stc_pkg::USRC_T0OF:   upper_tick = T0_OVERFLOW_EVENT;
			stc_pkg::USRC_AC1ES:  upper_tick = AC1_EVENT;
			stc_pkg::USRC_T1OF:   upper_tick = T1_OVERFLOW_EVENT;
		endcase

		// Duty capture counts from the first rising edge and freezes on the third,
		// so captured width and final period share one origin
		duty_hold = duty_mode && (((state_reg.duty == stc_pkg::DUTY_WAIT) && !cap_rise) ||
			((state_reg.duty == stc_pkg::DUTY_SECOND) && (cap_rise || cap_fall)));
		upper_go = UPPER_RUN && upper_tick && !state_reg.duty_stop && !duty_hold;
		ovf_u = SPLIT_ENABLE && upper_go && (state_reg.upper == stc_pkg::BYTE_MAX);
		ovf16 = !SPLIT_ENABLE && upper_go && (cnt16 == 16'hffff);
		timer_ovf = SPLIT_ENABLE ? low_ovf : ovf16;

		// Duty capture sequence on the capture input
		capture = 1'b0;
		if (!duty_mode || !UPPER_RUN) begin
			state_next.duty = stc_pkg::DUTY_WAIT;
			state_next.duty_stop = 1'b0;
		end else begin
			unique case (state_reg.duty)
				stc_pkg::DUTY_WAIT: begin
					if (cap_rise) begin
						state_next.duty = stc_pkg::DUTY_FIRST;
					end
				end
				stc_pkg::DUTY_FIRST: begin
					if (cap_rise || cap_fall) begin
						state_next.duty = stc_pkg::DUTY_SECOND;
						capture = 1'b1;
					end
				end
				stc_pkg::DUTY_SECOND: begin
					if (cap_rise || cap_fall) begin
						state_next.duty = stc_pkg::DUTY_DONE;
						state_next.duty_stop = 1'b1;
					end
				end
				stc_pkg::DUTY_DONE: begin
				end
			endcase
		end
		if ((mode == stc_pkg::MODE_CAPT) || (mode == stc_pkg::MODE_CAPT_AZ)) begin
			capture = ext_edge;
		end

		// Counting
		if (SPLIT_ENABLE) begin
			if (lower_go) begin
				state_next.lower = low_ovf ? state_reg.lower_rl : inc8(state_reg.lower);
			end
			if (upper_go) begin
				if (!ovf_u) begin
					state_next.upper = inc8(state_reg.upper);
				end else if (!CAPTURE_RELOAD_SELECT) begin
					state_next.upper = state_reg.upper_rl;
				end else begin
					state_next.upper = 8'h00;
				end
			end
			if (pwm_mode && ovf_u) begin
				state_next.lower = state_reg.lower_rl;
			end
		end else if (upper_go) begin
			if (ovf16 && !CAPTURE_RELOAD_SELECT) begin
				state_next.upper = state_reg.upper_rl;
				state_next.lower = state_reg.lower_rl;
			end else begin
				{state_next.upper, state_next.lower} = cnt16 + 16'h0001;
			end
		end

		// External edge actions
		if (capture) begin
			state_next.upper_rl = state_reg.upper;
			if (!SPLIT_ENABLE) begin
				state_next.lower_rl = state_reg.lower;
			end
		end
		if (ext_edge && (mode == stc_pkg::MODE_CAPT_AZ)) begin
			state_next.upper = 8'h00;
			if (!SPLIT_ENABLE) begin
				state_next.lower = 8'h00;
			end
		end
		if (ext_edge && (mode == stc_pkg::MODE_AR_TRIG)) begin
			state_next.upper = state_reg.upper_rl;
			if (!SPLIT_ENABLE) begin
				state_next.lower = state_reg.lower_rl;
			end
		end

		// Software writes land after hardware updates
		if (WR_UPPER_COUNT) begin
			state_next.upper = WR_DATA;
		end
		if (WR_LOWER_COUNT) begin
			state_next.lower = WR_DATA;
		end
		if (WR_UPPER_RELOAD) begin
			state_next.upper_rl = WR_DATA;
		end
		if (WR_LOWER_RELOAD) begin
			state_next.lower_rl = WR_DATA;
		end

		// Sticky flags, a set in the clearing cycle wins
		state_next.upper_flag = (state_reg.upper_flag && !CLR_UPPER_OVF) || ovf_u || ovf16;
		state_next.lower_flag = (state_reg.lower_flag && !CLR_LOWER_OVF) ||
			(low_ovf && !clkout_mode);
		state_next.ext_flag = (state_reg.ext_flag && !CLR_EXT_EVENT) ||
			(ext_edge && (!duty_mode || (state_reg.duty == stc_pkg::DUTY_FIRST)));

		// Output waveforms
		if (!clkout_mode) begin
			state_next.clk_tog = 1'b0;
		end else if (timer_ovf) begin
			state_next.clk_tog = !state_reg.clk_tog;
		end
		state_next.pwm_lvl = (state_reg.upper >= state_reg.lower);
		state_next.pin_out = CLOCK_OUT_ENABLE &&
			(pwm_mode ? state_reg.pwm_lvl : state_reg.clk_tog);
		state_next.tmr_ovf_ev = timer_ovf;
		state_next.low_ovf_ev = low_ovf;
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			state_reg <= stc_pkg::STATE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// ******************************************************************
	// Outputs
	// ******************************************************************
	assign UPPER_COUNT_BYTE     = state_reg.upper;
	assign LOWER_COUNT_BYTE     = state_reg.lower;
	assign UPPER_RELOAD_BYTE    = state_reg.upper_rl;
	assign LOWER_RELOAD_BYTE    = state_reg.lower_rl;
	assign UPPER_OVERFLOW_FLAG  = state_reg.upper_flag;
	assign LOWER_OVERFLOW_FLAG  = state_reg.lower_flag;
	assign EXTERNAL_EVENT_FLAG  = state_reg.ext_flag;
	assign TIMER_OVERFLOW_EVENT = state_reg.tmr_ovf_ev;
	assign LOWER_OVERFLOW_EVENT = state_reg.low_ovf_ev;
	assign CLOCK_OUT_PIN        = state_reg.pin_out;
	assign IRQ = (state_reg.upper_flag && !OVERFLOW_IGNORE) || state_reg.ext_flag ||
		(state_reg.lower_flag && LOWER_OVERFLOW_IRQ_ENABLE);

	// ******************************************************************
	// Assertions
	// ******************************************************************
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RESET);

	property p_pin_gated;
		!CLOCK_OUT_ENABLE |=> !CLOCK_OUT_PIN;
	endproperty
	a_pin_gated: assert property (p_pin_gated) else $error("clock-out pin not gated");

	property p_unsplit_flag;
		ovf16 |=> UPPER_OVERFLOW_FLAG;
	endproperty
	a_unsplit_flag: assert property (p_unsplit_flag) else $error("upper flag missed");

	property p_sticky;
		UPPER_OVERFLOW_FLAG && !CLR_UPPER_OVF |=> UPPER_OVERFLOW_FLAG;
	endproperty
	a_sticky: assert property (p_sticky) else $error("upper flag dropped");

	property p_toggle;
		clkout_mode && timer_ovf |=> state_reg.clk_tog != $past(state_reg.clk_tog);
	endproperty
	a_toggle: assert property (p_toggle) else $error("clock did not toggle");

	property p_reload16;
		ovf16 && !CAPTURE_RELOAD_SELECT && !WR_UPPER_COUNT |=>
			UPPER_COUNT_BYTE == $past(UPPER_RELOAD_BYTE);
	endproperty
	a_reload16: assert property (p_reload16) else $error("16-bit reload wrong");

	property p_pwm_copy;
		pwm_mode && ovf_u && !WR_LOWER_COUNT |=> LOWER_COUNT_BYTE == $past(LOWER_RELOAD_BYTE);
	endproperty
	a_pwm_copy: assert property (p_pwm_copy) else $error("duty buffer not copied");

	property p_no_lower_flag;
		clkout_mode && low_ovf && !LOWER_OVERFLOW_FLAG |=> !LOWER_OVERFLOW_FLAG;
	endproperty
	a_no_lower_flag: assert property (p_no_lower_flag) else $error("lower flag in clock-out");

	property p_irq_mask;
		!UPPER_OVERFLOW_FLAG && !EXTERNAL_EVENT_FLAG && !LOWER_OVERFLOW_IRQ_ENABLE |-> !IRQ;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("masked lower flag raised irq");

	property p_auto_zero;
		SPLIT_ENABLE && mode == stc_pkg::MODE_CAPT_AZ && ext_edge && !WR_UPPER_COUNT |=>
			UPPER_COUNT_BYTE == 8'h00;
	endproperty
	a_auto_zero: assert property (p_auto_zero) else $error("upper byte not zeroed");

	property p_split_event;
		SPLIT_ENABLE |=> TIMER_OVERFLOW_EVENT == $past(low_ovf);
	endproperty
	a_split_event: assert property (p_split_event) else $error("split overflow event wrong");

	property p_duty_freeze;
		duty_mode && state_reg.duty_stop && !WR_UPPER_COUNT |=> $stable(UPPER_COUNT_BYTE);
	endproperty
	a_duty_freeze: assert property (p_duty_freeze) else $error("duty capture did not stop");

	property p_lower_gate;
		SPLIT_ENABLE && !LOWER_RUN && !pwm_mode && !WR_LOWER_COUNT |=> $stable(LOWER_COUNT_BYTE);
	endproperty
	a_lower_gate: assert property (p_lower_gate) else $error("lower byte moved while stopped");

endmodule

// ### tb/stc_out_sink.sv
// Partner model: circuit fed by the clock-out pin, measures level run lengths
`timescale 1ns/1ps
module stc_out_sink (
	// Clock, reset and observed pin
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        pin,
	// Cycles spent in the last completed high and low runs
	output logic      [15:0] hi_len,
	output logic      [15:0] lo_len
);
	// ******************************************************************
	// Run length capture
	// ******************************************************************
	logic [15:0] run_reg;
	logic        last_reg;

	// Sampled on the same edge as the design, so lengths are whole cycles
	always @(posedge clk) begin
		if (rst) begin
			run_reg <= 16'h0000;
			last_reg <= 1'b0;
			hi_len <= 16'h0000;
			lo_len <= 16'h0000;
		end else begin
			if (pin !== last_reg) begin
				if (last_reg)
					hi_len <= run_reg;
				else
					lo_len <= run_reg;
				run_reg <= 16'h0001;
			end else begin
				run_reg <= run_reg + 16'h0001;
			end
			last_reg <= pin;
		end
	end
endmodule

// ### tb/tb_stc_split_timer.sv
// Testbench for the split timer: clock-out, split overflow, sources and PWM
`timescale 1ns/1ps
module tb_stc_split_timer;
	logic clk, rst, spl, mh, cr, ml, oe, urun, lrun, ign, lie, lch, lcl, s1, int1;
	logic [2:0] ucs;
	logic [7:0] wd, uc, lc, ur, lr, tmp;
	logic [6:0] stb;
	logic uf, lf, ef, irq, tev, lev, ckp, cap, erise;
	logic [15:0] hi, lo, ntev, nlev, b_tev, b_lev;
	int fail_count, n_tests, k;

	stc_split_timer uut (
		.CORE_CLK(clk), .RESET(rst), .SPLIT_ENABLE(spl), .MODE_SELECT_HIGH(mh),
		.CAPTURE_RELOAD_SELECT(cr), .MODE_SELECT_LOW(ml), .CLOCK_OUT_ENABLE(oe),
		.UPPER_RUN(urun), .LOWER_RUN(lrun), .OVERFLOW_IGNORE(ign),
		.LOWER_OVERFLOW_IRQ_ENABLE(lie), .EXT_FALL_ENABLE(1'b0), .EXT_RISE_ENABLE(erise),
		.UPPER_CLOCK_SELECT(ucs), .LOWER_CLOCK_SELECT_HIGH(lch),
		.LOWER_CLOCK_SELECT_LOW(lcl), .S1_OVERFLOW_EVENT(s1), .T0_OVERFLOW_EVENT(1'b0),
		.T1_OVERFLOW_EVENT(1'b0), .AC1_EVENT(1'b0), .INT1_EVENT(int1), .COUNT_PIN(1'b0),
		.CAPTURE_PIN(cap), .WR_DATA(wd), .WR_UPPER_COUNT(stb[0]), .WR_LOWER_COUNT(stb[1]),
		.WR_UPPER_RELOAD(stb[2]), .WR_LOWER_RELOAD(stb[3]), .CLR_UPPER_OVF(stb[4]),
		.CLR_LOWER_OVF(stb[5]), .CLR_EXT_EVENT(stb[6]), .UPPER_COUNT_BYTE(uc),
		.LOWER_COUNT_BYTE(lc), .UPPER_RELOAD_BYTE(ur), .LOWER_RELOAD_BYTE(lr),
		.UPPER_OVERFLOW_FLAG(uf), .LOWER_OVERFLOW_FLAG(lf), .EXTERNAL_EVENT_FLAG(ef),
		.IRQ(irq), .TIMER_OVERFLOW_EVENT(tev), .LOWER_OVERFLOW_EVENT(lev),
		.CLOCK_OUT_PIN(ckp));

	stc_out_sink sink (.clk(clk), .rst(rst), .pin(ckp), .hi_len(hi), .lo_len(lo));

	// ******************************************************************
	// Clock, event counters and access tasks
	// ******************************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (rst) begin
			ntev <= 16'h0000;
			nlev <= 16'h0000;
		end else begin
			if (tev === 1'b1)
				ntev <= ntev + 16'h0001;
			if (lev === 1'b1)
				nlev <= nlev + 16'h0001;
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Index: 0..3 count/reload writes, 4..6 flag clears
	task automatic wr(input int idx, input logic [7:0] d);
		@(negedge clk);
		wd = d;
		stb = 7'h00;
		stb[idx] = 1'b1;
		@(negedge clk);
		stb = 7'h00;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		if (fail_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Whole run is a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		final_report;
	end

	// ******************************************************************
	// Test sequence
	// ******************************************************************
	initial begin
		{spl, mh, cr, ml, oe, urun, lrun, ign, lie, lch, lcl, s1, int1} = 13'h0000;
		ucs = 3'h0;
		wd = 8'h00;
		stb = 7'h00;
		cap = 1'b0;
		erise = 1'b0;
		b_tev = 16'h0000;
		b_lev = 16'h0000;
		fail_count = 0;
		n_tests = 0;
		rst = 1'b1;
		cyc(6);
		rst = 1'b0;
		// Unsplit clock-out, reload 0xfffc: four cycles per half period
		ucs = 3'h2;
		wr(2, 8'hff);
		wr(3, 8'hfc);
		wr(0, 8'hff);
		wr(1, 8'hfc);
		oe = 1'b1;
		ign = 1'b1;
		urun = 1'b1;
		cyc(40);
		chk(hi, 16'h0004);
		chk(lo, 16'h0004);
		chk({15'h0, uf}, 16'h0001);
		chk({15'h0, irq}, 16'h0000);
		ign = 1'b0;
		cyc(1);
		chk({15'h0, irq}, 16'h0001);
		urun = 1'b0;
		oe = 1'b0;
		wr(4, 8'h00);
		cyc(1);
		chk({15'h0, uf}, 16'h0000);
		// Split clock-out from the lower byte, reload 0xfa
		spl = 1'b1;
		lcl = 1'b1;
		wr(3, 8'hfa);
		wr(1, 8'hfa);
		oe = 1'b1;
		lie = 1'b1;
		lrun = 1'b1;
		cyc(30);
		b_tev = ntev;
		b_lev = nlev;
		cyc(60);
		chk(ntev - b_tev, 16'h000a);
		chk(nlev - b_lev, 16'h000a);
		chk(hi, 16'h0006);
		chk(lo, 16'h0006);
		chk({15'h0, lf}, 16'h0000);
		chk({15'h0, irq}, 16'h0000);
		// Split timer without clock-out: lower flag and run gate
		oe = 1'b0;
		lie = 1'b0;
		wr(3, 8'hfe);
		wr(1, 8'hfe);
		cyc(4);
		chk({15'h0, lf}, 16'h0001);
		chk({15'h0, irq}, 16'h0000);
		lie = 1'b1;
		cyc(1);
		chk({15'h0, irq}, 16'h0001);
		lrun = 1'b0;
		cyc(1);
		tmp = lc;
		cyc(10);
		chk({8'h0, lc}, {8'h0, tmp});
		chk({15'h0, lf}, 16'h0001);
		wr(5, 8'h00);
		cyc(1);
		chk({15'h0, lf}, 16'h0000);
		// Four lower clock sources, counted from zero
		for (k = 0; k < 4; k++) begin
			{lch, lcl} = k[1:0];
			wr(1, 8'h00);
			lrun = 1'b1;
			if (k == 0)
				cyc(24);
			else if (k == 1)
				cyc(10);
			else begin
				repeat (4) begin
					s1 = (k == 2);
					int1 = (k == 3);
					cyc(1);
					s1 = 1'b0;
					int1 = 1'b0;
					cyc(1);
				end
			end
			lrun = 1'b0;
			cyc(1);
			chk({8'h0, lc}, (k == 0) ? 16'h0002 : (k == 1) ? 16'h000a : 16'h0004);
		end
		// Split PWM: period 16, compare 0xf8 then buffered 0xf4
		mh = 1'b1;
		wr(2, 8'hf0);
		wr(0, 8'hf0);
		wr(3, 8'hf8);
		wr(1, 8'hf8);
		oe = 1'b1;
		urun = 1'b1;
		cyc(50);
		chk(hi, 16'h0008);
		chk(lo, 16'h0008);
		wr(3, 8'hf4);
		cyc(20);
		chk({8'h0, lc}, 16'h00f4);
		chk({15'h0, uf}, 16'h0001);
		cyc(40);
		chk(hi, 16'h000c);
		chk(lo, 16'h0004);
		oe = 1'b0;
		cyc(3);
		chk({15'h0, ckp}, 16'h0000);
		cyc(20);
		chk({15'h0, ckp}, 16'h0000);
		// Split capture with auto-zero on a rising capture edge
		urun = 1'b0;
		wr(0, 8'h10);
		{mh, cr, ml} = 3'b011;
		erise = 1'b1;
		urun = 1'b1;
		cap = 1'b1;
		cyc(3);
		chk({8'h0, ur}, 16'h0012);
		chk({8'h0, uc}, 16'h0000);
		chk({8'h0, lr}, 16'h00f4);
		chk({8'h0, lc}, 16'h00f4);
		chk({15'h0, ef}, 16'h0001);
		// Split duty capture: high for 5 cycles, period 15 cycles
		urun = 1'b0;
		cap = 1'b0;
		wr(6, 8'h00);
		{mh, cr, ml} = 3'b110;
		wr(0, 8'h00);
		urun = 1'b1;
		cyc(3);
		cap = 1'b1;
		cyc(5);
		cap = 1'b0;
		cyc(10);
		cap = 1'b1;
		cyc(8);
		chk({8'h0, ur}, 16'h0005);
		chk({8'h0, uc}, 16'h000f);
		chk({15'h0, ef}, 16'h0000);
		final_report;
	end
endmodule
